/* rtl/pm1_pkg.sv */
// Constants, types and register layout for the power-management event block.
// Assumes a single 25 MHz system clock and register access through config and IO space.
package pm1_pkg;
  // ******************************************************
  // Register offsets and fields
  // ******************************************************
  localparam logic [7:0] OFS_STATUS_ENABLE = 8'h00;
  localparam logic [7:0] OFS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_TIMER = 8'h08;
  localparam logic [7:0] OFS_MON_ONE = 8'hd0;
  localparam logic [7:0] OFS_MON_TWO = 8'hd4;
  localparam logic [7:0] OFS_MON_MASKS = 8'hd8;
  localparam int BIT_TMR = 0;
  localparam int BIT_BM = 4;
  localparam int BIT_GBL = 5;
  localparam int BIT_PWR = 8;
  localparam int BIT_SLP = 9;
  localparam int BIT_RTC = 10;
  localparam int BIT_PBOR = 11;
  localparam int BIT_WAK = 15;
  localparam logic [15:0] STATUS_USED = 16'h8f31;
  localparam logic [15:0] ENABLE_USED = 16'h0721;
  localparam logic [15:0] BUTTON_EVENTS = 16'h0700;
  localparam int BIT_TYPE_SEL = 0;
  localparam int BIT_BUS_MASTER_C3_RESUME = 1;
  localparam int BIT_GLOBAL_RELEASE = 2;
  localparam int SLEEP_TYPE_LO = 10;
  localparam int BIT_SLP_GO = 13;
  localparam int MEM_ADDR_LO = 8;
  localparam int NARROW_MSB = 23;
  localparam int WIDE_MSB = 31;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [31:0] MON_RESET = 32'h0000_0000;
  // ******************************************************
  // Timing
  // ******************************************************
  localparam int CLK_HZ = 25000000;
  localparam int DEBOUNCE_MS = 12;
  localparam int DEBOUNCE_CYCLES = (CLK_HZ / 1000) * DEBOUNCE_MS;
  localparam int OVERRIDE_S = 4;
  localparam int OVERRIDE_CYCLES = CLK_HZ * OVERRIDE_S;
  // ******************************************************
  // Types
  // ******************************************************
  typedef enum logic [2:0] {
    full_on = 3'b000,
    power_on_suspend = 3'b001,
    suspend_to_ram = 3'b101,
    suspend_to_disk = 3'b110,
    soft_off = 3'b111
  } sleep_type_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic cfg_space;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } reg_req_t;
endpackage

/* rtl/mem_range_match.sv */
// Address comparator for one programmable memory range monitor.
// Assumes the address is sampled in a PCI memory address phase by the caller.
`timescale 1ns/10ps
`default_nettype none
module mem_range_match
  import pm1_pkg::*;
(
  // Observed address and programmed window.
  input wire logic [31:0] pci_addr,
  input wire logic [23:0] base,
  input wire logic [15:0] mask,
  // Match result.
  output logic hit
);
  // Only address bits 23:8 can be masked; bits 31:24 always compare.
  logic [23:0] wide_mask;
  assign wide_mask = {8'h00, mask};
  assign hit = ((pci_addr[31:MEM_ADDR_LO] | wide_mask) == (base | wide_mask));
endmodule
`default_nettype wire

/* rtl/button_debounce.sv */
// Two-edge debouncer with a long-hold detector for one button.
// Assumes the pin is synchronous to clk_sys and active low.
`timescale 1ns/10ps
`default_nettype none
module button_debounce
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Pin and timing.
  input wire logic pin_n,
  input wire logic [31:0] period,
  input wire logic [31:0] hold_limit,
  // Results.
  output logic press,
  output logic long_hold
);
  logic stable_n_q;
  logic [31:0] bounce_q;
  logic [31:0] hold_q;

  // The stable level follows the pin only after it stays put for a full period.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stable_n_q <= 1'b1;
      bounce_q <= 32'h0000_0000;
      press <= 1'b0;
    end
    else
    begin
      press <= 1'b0;
      if (pin_n == stable_n_q)
        bounce_q <= 32'h0000_0000;
      else if (bounce_q >= period - 32'h0000_0001)
      begin
        bounce_q <= 32'h0000_0000;
        stable_n_q <= pin_n;
        press <= !pin_n;
      end
      else
        bounce_q <= bounce_q + 32'h0000_0001;
    end
  end

  // Counts how long the debounced button stays pressed; fires once.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hold_q <= 32'h0000_0000;
      long_hold <= 1'b0;
    end
    else
    begin
      long_hold <= 1'b0;
      if (stable_n_q)
        hold_q <= 32'h0000_0000;
      else if (hold_q != hold_limit)
      begin
        hold_q <= hold_q + 32'h0000_0001;
        long_hold <= (hold_q == hold_limit - 32'h0000_0001);
      end
    end
  end
endmodule
`default_nettype wire

/* rtl/pm1_event_block.sv */
// Power-management event block: status, enables, control, timer and memory monitors.
// Assumes synchronous inputs, a one-cycle timer tick at 3.579545 MHz and one-cycle register strobes.
`timescale 1ns/10ps
`default_nettype none
module pm1_event_block
  import pm1_pkg::*;
#(
  parameter int DEBOUNCE_LEN = DEBOUNCE_CYCLES,
  parameter int OVERRIDE_LEN = OVERRIDE_CYCLES
)
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register access from config and IO space.
  input wire pm1_pkg::reg_req_t reg_req,
  output logic [31:0] reg_rdata_q,
  // PCI snooping and bus master requests.
  input wire logic pci_mem_phase,
  input wire logic [31:0] pci_addr,
  input wire logic [7:0] pci_req_n,
  input wire logic bus_master_req_n,
  input wire logic internal_master_req,
  // Buttons, wake sources and configuration.
  input wire logic power_button_in_n,
  input wire logic sleep_button_in_n,
  input wire logic power_override_disable,
  input wire logic sleep_override_disable,
  input wire logic sleep_pin_select,
  input wire logic gpio_debounce_en,
  input wire logic clock_alarm,
  input wire logic resume_event,
  input wire logic mechanical_off,
  input wire logic firmware_release,
  input wire logic firmware_handshake_clear,
  input wire logic trap_to_smi,
  input wire logic trap_to_sci,
  input wire logic trap_to_reload,
  // Timer configuration.
  input wire logic timer_tick,
  input wire logic timer_wide,
  input wire logic timer_clear,
  // Event outputs.
  output logic sci_q,
  output logic smi_q,
  output logic inactivity_reload_q,
  output logic [1:0] mem_trap_q,
  output logic firmware_handshake_q,
  output logic c3_resume_q,
  output logic sleep_start_q,
  output logic resume_q,
  output pm1_pkg::sleep_type_t sleep_state_q
);
  // ******************************************************
  // Declarations and decoding
  // ******************************************************
  logic [15:0] status_q;
  logic [15:0] enable_q;
  logic type_select_q;
  logic bus_master_c3_resume_q;
  logic global_release_q;
  logic [2:0] sleep_type_q;
  logic [31:0] timer_q;
  logic msb_prev_q;
  logic [23:0] mon_base_q [2];
  logic [31:0] mon_masks_q;
  logic [1:0] hit;
  logic io_wr;
  logic [31:0] wmask;
  logic [31:0] lane_mask;
  logic [15:0] status_clr;
  logic [15:0] status_set;
  logic msb_now;
  logic power_press;
  logic power_hold;
  logic sleep_press;
  logic sleep_hold;
  logic [31:0] sleep_period;
  logic btn_irq;
  logic trap_any;
  logic wake_cause;
  logic release_set;

  // Expands byte enables into a bit mask.
  function automatic logic [31:0] lanes(input logic [3:0] be);
    lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // Tells whether a write hits one register in the chosen space.
  function automatic logic hits(input reg_req_t r, input logic cfg, input logic [7:0] ofs);
    hits = r.wr && (r.cfg_space == cfg) && (r.addr == ofs);
  endfunction

  assign lane_mask = lanes(reg_req.be);
  assign wmask = reg_req.wdata & lane_mask;
  assign io_wr = hits(reg_req, 1'b0, OFS_STATUS_ENABLE);
  assign status_clr = io_wr ? wmask[15:0] : 16'h0000;
  assign msb_now = timer_wide ? timer_q[WIDE_MSB] : timer_q[NARROW_MSB];
  assign release_set = hits(reg_req, 1'b0, OFS_CONTROL) && wmask[BIT_GLOBAL_RELEASE] && !global_release_q;

  // ******************************************************
  // Memory range monitors
  // ******************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_mon
      mem_range_match u_match (
        .pci_addr(pci_addr),
        .base(mon_base_q[gi]),
        .mask(mon_masks_q[16*gi +: 16]),
        .hit(hit[gi])
      );
    end
  endgenerate

  // Every memory address phase is snooped, whoever it targets.
  assign trap_any = pci_mem_phase && (|hit);

  // Trap events are flagged and routed to SMI, SCI or the inactivity timer.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_trap_q <= 2'b00;
      inactivity_reload_q <= 1'b0;
    end
    else
    begin
      mem_trap_q <= pci_mem_phase ? hit : 2'b00;
      inactivity_reload_q <= trap_any && trap_to_reload;
    end
  end

  // ******************************************************
  // Buttons
  // ******************************************************
  // The sleep button period doubles when GPIO debounce is on.
  assign sleep_period = gpio_debounce_en ? DEBOUNCE_LEN * 2 : DEBOUNCE_LEN;

  button_debounce u_power (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_n(power_button_in_n),
    .period(DEBOUNCE_LEN),
    .hold_limit(OVERRIDE_LEN),
    .press(power_press),
    .long_hold(power_hold)
  );

  button_debounce u_sleep (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_n(sleep_button_in_n),
    .period(sleep_period),
    .hold_limit(OVERRIDE_LEN),
    .press(sleep_press),
    .long_hold(sleep_hold)
  );

  // ******************************************************
  // Status register
  // ******************************************************
  // Hardware set sources; a set arriving with a clear wins.
  always_comb
  begin
    status_set = 16'h0000;
    status_set[BIT_TMR] = timer_tick_seen();
    status_set[BIT_BM] = !(&pci_req_n) || !bus_master_req_n || internal_master_req;
    status_set[BIT_GBL] = firmware_release;
    status_set[BIT_PWR] = power_press;
    status_set[BIT_SLP] = sleep_press && sleep_pin_select;
    status_set[BIT_RTC] = clock_alarm;
    status_set[BIT_PBOR] = (power_hold && !power_override_disable) ||
                           (sleep_hold && !sleep_override_disable && sleep_pin_select);
    status_set[BIT_WAK] = wake_cause;
  end

  // Toggle of the timer's top bit in either direction.
  function automatic logic timer_tick_seen();
    timer_tick_seen = (msb_now != msb_prev_q);
  endfunction

  // A resume event, or an enabled alarm or button press, while asleep sets the wake flag; sources are taken directly so no status loop forms.
  assign wake_cause = (sleep_state_q != full_on) && (resume_event ||
                      (|({clock_alarm, sleep_press && sleep_pin_select, power_press} & enable_q[BIT_RTC:BIT_PWR])));

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      status_q <= STATUS_RESET;
    else
    begin
      status_q <= ((status_q & ~status_clr) | status_set) & STATUS_USED;
      if (power_hold && !power_override_disable)
        status_q[BIT_PWR] <= 1'b0;
      if (sleep_hold && !sleep_override_disable && sleep_pin_select)
        status_q[BIT_SLP] <= 1'b0;
    end
  end

  // ******************************************************
  // Enable, control and monitor registers
  // ******************************************************
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      enable_q <= ENABLE_RESET;
      type_select_q <= 1'b0;
      bus_master_c3_resume_q <= 1'b0;
      sleep_type_q <= 3'h0;
      mon_base_q[0] <= MON_RESET[31:8];
      mon_base_q[1] <= MON_RESET[31:8];
      mon_masks_q <= MON_RESET;
    end
    else
    begin
      if (io_wr)
        enable_q <= ((enable_q & ~lane_mask[31:16]) | wmask[31:16]) & ENABLE_USED;
      if (hits(reg_req, 1'b0, OFS_CONTROL) && reg_req.be[0])
      begin
        type_select_q <= reg_req.wdata[BIT_TYPE_SEL];
        bus_master_c3_resume_q <= reg_req.wdata[BIT_BUS_MASTER_C3_RESUME];
      end
      if (hits(reg_req, 1'b0, OFS_CONTROL) && reg_req.be[1])
        sleep_type_q <= reg_req.wdata[SLEEP_TYPE_LO +: 3];
      if (hits(reg_req, 1'b1, OFS_MON_ONE))
        mon_base_q[0] <= ((mon_base_q[0] & ~lane_mask[31:8]) | wmask[31:8]);
      if (hits(reg_req, 1'b1, OFS_MON_TWO))
        mon_base_q[1] <= ((mon_base_q[1] & ~lane_mask[31:8]) | wmask[31:8]);
      if (hits(reg_req, 1'b1, OFS_MON_MASKS))
        mon_masks_q <= (mon_masks_q & ~lane_mask) | wmask;
    end
  end

  // Release handshake: release raises the firmware flag, clearing that flag drops release.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      global_release_q <= 1'b0;
      firmware_handshake_q <= 1'b0;
    end
    else
    begin
      firmware_handshake_q <= (firmware_handshake_q && !firmware_handshake_clear) || release_set;
      if (release_set)
        global_release_q <= 1'b1;
      else if (firmware_handshake_clear && firmware_handshake_q)
        global_release_q <= 1'b0;
    end
  end

  // ******************************************************
  // Sleep sequencing
  // ******************************************************
  // Sleep go is a strobe only; reserved sleep types are ignored.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sleep_state_q <= full_on;
      sleep_start_q <= 1'b0;
      resume_q <= 1'b0;
    end
    else
    begin
      sleep_start_q <= 1'b0;
      resume_q <= 1'b0;
      if (wake_cause)
      begin
        sleep_state_q <= full_on;
        resume_q <= 1'b1;
      end
      else if (hits(reg_req, 1'b0, OFS_CONTROL) && reg_req.be[1] && reg_req.wdata[BIT_SLP_GO])
      begin
        case (reg_req.wdata[SLEEP_TYPE_LO +: 3])
          3'b000, 3'b001, 3'b101, 3'b110, 3'b111:
          begin
            sleep_state_q <= sleep_type_t'(reg_req.wdata[SLEEP_TYPE_LO +: 3]);
            sleep_start_q <= 1'b1;
          end
          default:
            sleep_state_q <= sleep_state_q;
        endcase
      end
    end
  end

  // ******************************************************
  // Power-management timer
  // ******************************************************
  // Free-running up-counter, held in deep sleep, cleared while the clear bit is high.
  always_ff @(posedge clk_sys or negedge rst_n or posedge timer_clear)
  begin
    if (!rst_n)
      timer_q <= 32'h0000_0000;
    else if (timer_clear)
      timer_q <= 32'h0000_0000;
    else if (timer_tick && !mechanical_off && sleep_state_q != soft_off &&
             sleep_state_q != suspend_to_disk && sleep_state_q != suspend_to_ram)
      timer_q <= timer_q + 32'h0000_0001;
  end

  // Remembers the previous top bit for toggle detection.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      msb_prev_q <= 1'b0;
    else
      msb_prev_q <= msb_now;
  end

  // ******************************************************
  // Interrupt routing and read data
  // ******************************************************
  assign btn_irq = |(status_q & enable_q & BUTTON_EVENTS);

  // Requests stay up while an enabled status bit is set.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sci_q <= 1'b0;
      smi_q <= 1'b0;
      c3_resume_q <= 1'b0;
    end
    else
    begin
      sci_q <= (status_q[BIT_TMR] && enable_q[BIT_TMR]) ||
               (status_q[BIT_GBL] && enable_q[BIT_GBL]) ||
               (type_select_q && btn_irq) || (trap_any && trap_to_sci);
      smi_q <= (!type_select_q && btn_irq) || (trap_any && trap_to_smi);
      c3_resume_q <= bus_master_c3_resume_q && status_q[BIT_BM];
    end
  end

  // Read data is registered; unmapped offsets read zero.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata_q <= 32'h0000_0000;
    else if (reg_req.rd)
    begin
      reg_rdata_q <= 32'h0000_0000;
      if (!reg_req.cfg_space && reg_req.addr == OFS_STATUS_ENABLE)
        reg_rdata_q <= {enable_q, status_q};
      else if (!reg_req.cfg_space && reg_req.addr == OFS_CONTROL)
        reg_rdata_q <= {19'h00000, sleep_type_q, 7'h00, global_release_q,
                        bus_master_c3_resume_q, type_select_q};
      else if (!reg_req.cfg_space && reg_req.addr == OFS_TIMER)
        reg_rdata_q <= {timer_wide ? timer_q[31:24] : 8'h00, timer_q[23:0]};
      else if (reg_req.cfg_space && reg_req.addr == OFS_MON_ONE)
        reg_rdata_q <= {mon_base_q[0], 8'h00};
      else if (reg_req.cfg_space && reg_req.addr == OFS_MON_TWO)
        reg_rdata_q <= {mon_base_q[1], 8'h00};
      else if (reg_req.cfg_space && reg_req.addr == OFS_MON_MASKS)
        reg_rdata_q <= mon_masks_q;
    end
  end

  // ******************************************************
  // Assertions
  // ******************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  mon_one_hit_a: assert property (pci_mem_phase &&
    ((pci_addr[31:8] | {8'h00, mon_masks_q[15:0]}) == (mon_base_q[0] | {8'h00, mon_masks_q[15:0]}))
    |=> mem_trap_q[0]) else $error("monitor one missed a match");
  upper_unmasked_a: assert property (mem_trap_q[1] |->
    $past(pci_addr[31:24]) == $past(mon_base_q[1][23:16])) else $error("upper bits were masked");
  trap_reload_a: assert property (trap_any && trap_to_reload |=> inactivity_reload_q)
    else $error("trap did not reload");
  clear_timer_flag_a: assert property (io_wr && reg_req.be[0] && reg_req.wdata[0] && !status_set[0]
    |=> !status_q[BIT_TMR]) else $error("write one did not clear");
  msb_toggle_a: assert property ($changed(msb_now) && !$changed(timer_wide) |-> ##1 status_q[BIT_TMR])
    else $error("toggle not flagged");
  bm_flag_a: assert property (!bus_master_req_n |=> status_q[BIT_BM]) else $error("bus master missed");
  release_flag_a: assert property (global_release_q |-> firmware_handshake_q ##0 1)
    else $error("release without handshake");
  sleep_gate_a: assert property (!sleep_pin_select && !status_q[BIT_SLP] |=> !status_q[BIT_SLP])
    else $error("sleep flag set without pin");
  timer_sci_a: assert property (status_q[BIT_TMR] && enable_q[BIT_TMR] |=> sci_q)
    else $error("timer flag gave no sci");
  smi_route_a: assert property (!type_select_q && btn_irq |=> smi_q && (!sci_q ||
    $past((status_q[BIT_TMR] && enable_q[BIT_TMR]) || (status_q[BIT_GBL] && enable_q[BIT_GBL]) || trap_any)))
    else $error("button event not smi");
  sleep_zero_a: assert property (reg_req.rd && !reg_req.cfg_space && reg_req.addr == OFS_CONTROL
    |=> !reg_rdata_q[BIT_SLP_GO]) else $error("sleep go read as one");
  timer_hold_a: assert property (sleep_state_q == suspend_to_ram && !timer_clear ##1 !timer_clear
    |-> $stable(timer_q)) else $error("timer ran in suspend");
  narrow_read_a: assert property (reg_req.rd && !reg_req.cfg_space && reg_req.addr == OFS_TIMER &&
    !timer_wide |=> reg_rdata_q[31:24] == 8'h00) else $error("upper timer byte not zero");

  trap_seen_c: cover property (mem_trap_q[0] ##1 smi_q);
  sleep_wake_c: cover property (sleep_start_q ##[1:50] resume_q);
  override_c: cover property ($rose(status_q[BIT_PBOR]));
endmodule
`default_nettype wire

/* tb/pci_master_model.sv */
// PCI bus master model: memory address phases and bus requests.
// Assumes the bench calls its tasks at the falling clock edge.
`timescale 1ns/10ps
`default_nettype none
module pci_master_model
(
  // Clock.
  input wire logic clk_sys,
  // Bus side.
  output logic pci_mem_phase,
  output logic [31:0] pci_addr,
  output logic [7:0] pci_req_n
);
  // Idle bus: no phase and no request.
  initial
  begin
    pci_mem_phase = 1'b0;
    pci_addr = 32'h0000_0000;
    pci_req_n = 8'hff;
  end
  // One address phase after an idle edge; afterwards the address shows its inverse, not a stale match.
  task automatic phase(input logic [31:0] a);
    @(negedge clk_sys);
    pci_mem_phase = 1'b1;
    pci_addr = a;
    @(negedge clk_sys);
    pci_mem_phase = 1'b0;
    pci_addr = ~a;
  endtask
  // One request pulse on line i.
  task automatic req(input int i);
    pci_req_n[i] = 1'b0;
    @(negedge clk_sys);
    pci_req_n[i] = 1'b1;
  endtask
endmodule
`default_nettype wire

/* tb/pm1_event_block_tb_top.sv */
// Self-checking bench for the power-management event block.
// Assumes the PCI master model and short debounce and override counts.
`timescale 1ns/10ps
`default_nettype none
module pm1_event_block_tb_top;
  import pm1_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  reg_req_t reg_req = '0;
  logic [31:0] reg_rdata_q, pci_addr, t;
  logic [7:0] pci_req_n;
  logic [1:0] mem_trap_q;
  sleep_type_t sleep_state_q;
  logic pci_mem_phase, sci_q, smi_q, inactivity_reload_q, firmware_handshake_q, c3_resume_q, sleep_start_q, resume_q;
  logic bus_master_req_n, internal_master_req, power_button_in_n, sleep_button_in_n, power_override_disable;
  logic sleep_override_disable, sleep_pin_select, gpio_debounce_en, clock_alarm, resume_event, mechanical_off;
  logic firmware_release, firmware_handshake_clear, trap_to_smi, trap_to_sci, trap_to_reload;
  logic timer_tick = 1'b0, timer_wide, timer_clear;
  int fail_count = 0, total_checks = 0;
  pm1_event_block #(.DEBOUNCE_LEN(8), .OVERRIDE_LEN(40)) dut_u (.clk_sys, .rst_n, .reg_req, .reg_rdata_q,
    .pci_mem_phase, .pci_addr, .pci_req_n, .bus_master_req_n, .internal_master_req, .power_button_in_n,
    .sleep_button_in_n, .power_override_disable, .sleep_override_disable, .sleep_pin_select, .gpio_debounce_en,
    .clock_alarm, .resume_event, .mechanical_off, .firmware_release, .firmware_handshake_clear, .trap_to_smi,
    .trap_to_sci, .trap_to_reload, .timer_tick, .timer_wide, .timer_clear, .sci_q, .smi_q, .inactivity_reload_q,
    .mem_trap_q, .firmware_handshake_q, .c3_resume_q, .sleep_start_q, .resume_q, .sleep_state_q);
  pci_master_model pm (.clk_sys, .pci_mem_phase, .pci_addr, .pci_req_n);
  // Clock and a timer tick about every seventh cycle.
  always #20 clk_sys = ~clk_sys;
  always
  begin
    repeat (6) @(negedge clk_sys);
    timer_tick = 1'b1;
    @(negedge clk_sys);
    timer_tick = 1'b0;
  end
  // Compare and count.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One register access held for one edge, after an idle edge so back-to-back calls never retoggle the strobe.
  task automatic acc(input logic w, input logic c, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(negedge clk_sys);
    reg_req = {w, ~w, c, a, b, d};
    @(negedge clk_sys);
    reg_req = '0;
  endtask
  task automatic rd(input logic c, input logic [7:0] a, input logic [31:0] exp);
    acc(1'b0, c, a, 4'hf, 32'h0);
    chk(reg_rdata_q, exp);
  endtask
  task automatic test_done();
    if (fail_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog.
  initial
  begin
    #100000;
    fail_count++;
    test_done();
  end
  // Main sequence.
  initial
  begin
    {bus_master_req_n, power_button_in_n, sleep_button_in_n, trap_to_smi} = 4'hf;
    {internal_master_req, power_override_disable, sleep_override_disable, sleep_pin_select, gpio_debounce_en} = '0;
    {clock_alarm, resume_event, mechanical_off, firmware_release, firmware_handshake_clear} = '0;
    {trap_to_sci, trap_to_reload, timer_wide, timer_clear} = '0;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    rd(1'b0, OFS_STATUS_ENABLE, 32'h0);
    rd(1'b1, 8'h40, 32'h0);
    acc(1'b1, 1'b1, OFS_MON_ONE, 4'hf, 32'h1234_5600);
    acc(1'b1, 1'b1, OFS_MON_MASKS, 4'hf, 32'h0000_00ff);
    pm.phase(32'h1234_ab10);
    chk(mem_trap_q, 2'b01);
    chk(smi_q, 1'b1);
    pm.phase(32'h1235_5610);
    chk(mem_trap_q, 2'b00);
    {trap_to_sci, trap_to_reload} = 2'b11;
    pm.phase(32'h0000_0020);
    chk(mem_trap_q, 2'b10);
    chk(inactivity_reload_q, 1'b1);
    chk(sci_q, 1'b1);
    {trap_to_sci, trap_to_reload} = 2'b00;
    acc(1'b1, 1'b0, OFS_CONTROL, 4'h3, 32'h0000_0002);
    pm.req(2);
    @(negedge clk_sys);
    chk(c3_resume_q, 1'b1);
    rd(1'b0, OFS_STATUS_ENABLE, 32'h0000_0010);
    acc(1'b1, 1'b0, OFS_STATUS_ENABLE, 4'h3, 32'h0000_0010);
    bus_master_req_n = 1'b0;
    @(negedge clk_sys);
    bus_master_req_n = 1'b1;
    rd(1'b0, OFS_STATUS_ENABLE, 32'h0000_0010);
    acc(1'b1, 1'b0, OFS_STATUS_ENABLE, 4'h3, 32'h0000_0010);
    rd(1'b0, OFS_STATUS_ENABLE, 32'h0);
    // Power button press, then a hold past the override count.
    acc(1'b1, 1'b0, OFS_STATUS_ENABLE, 4'hc, 32'h0100_0000);
    acc(1'b1, 1'b0, OFS_CONTROL, 4'h3, 32'h0000_0001);
    power_button_in_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk(sci_q, 1'b0);
    repeat (8) @(negedge clk_sys);
    chk(sci_q, 1'b1);
    rd(1'b0, OFS_STATUS_ENABLE, 32'h0100_0100);
    repeat (50) @(negedge clk_sys);
    rd(1'b0, OFS_STATUS_ENABLE, 32'h0100_0800);
    power_button_in_n = 1'b1;
    repeat (12) @(negedge clk_sys);
    acc(1'b1, 1'b0, OFS_STATUS_ENABLE, 4'hf, 32'h0000_0800);
    rd(1'b0, OFS_STATUS_ENABLE, 32'h0);
    // Sleep into suspend to RAM; the timer holds; then wake.
    acc(1'b1, 1'b0, OFS_CONTROL, 4'h3, 32'h0000_3400);
    repeat (4) if (sleep_start_q !== 1'b1) @(negedge clk_sys);
    chk(sleep_start_q, 1'b1);
    chk(sleep_state_q, suspend_to_ram);
    rd(1'b0, OFS_CONTROL, 32'h0000_1400);
    acc(1'b0, 1'b0, OFS_TIMER, 4'hf, 32'h0);
    t = reg_rdata_q;
    repeat (20) @(negedge clk_sys);
    rd(1'b0, OFS_TIMER, t);
    resume_event = 1'b1;
    @(negedge clk_sys);
    resume_event = 1'b0;
    repeat (4) if (resume_q !== 1'b1) @(negedge clk_sys);
    chk(resume_q, 1'b1);
    chk(sleep_state_q, full_on);
    rd(1'b0, OFS_STATUS_ENABLE, 32'h0000_8000);
    acc(1'b1, 1'b0, OFS_STATUS_ENABLE, 4'hf, 32'h0020_8000);
    acc(1'b1, 1'b0, OFS_CONTROL, 4'h3, 32'h0000_2c00);
    repeat (3) @(negedge clk_sys);
    chk(sleep_state_q, full_on);
    // Release raises the handshake; a firmware release sets the global flag, which gives SCI with SMI selected.
    acc(1'b1, 1'b0, OFS_CONTROL, 4'h3, 32'h0000_0004);
    firmware_release = 1'b1;
    repeat (2) @(negedge clk_sys);
    firmware_release = 1'b0;
    chk(firmware_handshake_q, 1'b1);
    chk(sci_q, 1'b1);
    rd(1'b0, OFS_CONTROL, 32'h0000_0004);
    firmware_handshake_clear = 1'b1;
    @(negedge clk_sys);
    firmware_handshake_clear = 1'b0;
    @(negedge clk_sys);
    rd(1'b0, OFS_CONTROL, 32'h0);
    // Narrow timer and its clear.
    acc(1'b0, 1'b0, OFS_TIMER, 4'hf, 32'h0);
    chk(reg_rdata_q[31:24], 8'h00);
    chk(reg_rdata_q == 32'h0, 1'b0);
    timer_clear = 1'b1;
    rd(1'b0, OFS_TIMER, 32'h0);
    timer_clear = 1'b0;
    test_done();
  end
endmodule
`default_nettype wire
